// file: common/hss_pkg.sv
// constants and types for the high-voltage startup sequencer
package hss_pkg;
    localparam int CLK_HZ            = 10_000_000;
    localparam int START_DELAY_NS    = 34_000;
    localparam int START_DELAY_CYC   = (START_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OFF_DELAY_NS      = 10_000;
    localparam int OFF_DELAY_CYC     = (OFF_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OVP_DELAY_NS      = 20_000;
    localparam int OVP_DELAY_CYC     = (OVP_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BROWNIN_DELAY_NS  = 20_000;
    localparam int BROWNIN_DELAY_CYC = (BROWNIN_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TIMER_W           = 16;
    localparam int FREQ_W            = 12;
    // frequency code in kHz
    localparam logic [11:0] SS_START_KHZ = 12'h01F;
    localparam logic [11:0] SS_STEP_KHZ  = 12'h001;
    localparam int SS_STEP_CYC       = 64;
    typedef enum logic [1:0] {CUR_OFF, CUR_LOW, CUR_HIGH} hss_cur_e;
endpackage

// file: common/hss_cmp_if.sv
// synchronised comparator bundle between the front end and the sequencer
`timescale 1ns/1ps
interface hss_cmp_if;
    logic lineDischarge;
    logic lineMinimum;
    logic lineBrownIn;
    logic supplyInhibit;
    logic supplyOn;
    logic supplyOff;
    logic supplyOvp;
    logic supplyReset;
    logic faultInput;
    modport src (output lineDischarge, lineMinimum, lineBrownIn, supplyInhibit, supplyOn,
                 supplyOff, supplyOvp, supplyReset, faultInput);
    modport dst (input lineDischarge, lineMinimum, lineBrownIn, supplyInhibit, supplyOn,
                 supplyOff, supplyOvp, supplyReset, faultInput);
endinterface

// file: design/hss_sync.sv
// three-stage synchronisers for the comparator inputs
`timescale 1ns/1ps
module hss_sync
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // raw comparator levels
    input  wire logic [8:0] rawIn,
    // synchronised bundle
    hss_cmp_if.src        cmp
);
    logic [8:0] s1_reg, s2_reg, s3_reg, val_reg;
    logic [8:0] s1_next, s2_next, s3_next, val_next;

    always_comb
    begin
        s1_next = rawIn;
        s2_next = s1_reg;
        s3_next = s2_reg;
        // a change counts only once stages two and three agree
        val_next = val_reg;
        for (int i = 0; i < 9; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                val_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_reg  <= 9'h000;
            s2_reg  <= 9'h000;
            s3_reg  <= 9'h000;
            val_reg <= 9'h000;
        end
        else
        begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            val_reg <= val_next;
        end
    end

    assign cmp.lineDischarge = val_reg[0];
    assign cmp.lineMinimum   = val_reg[1];
    assign cmp.lineBrownIn   = val_reg[2];
    assign cmp.supplyInhibit = val_reg[3];
    assign cmp.supplyOn      = val_reg[4];
    assign cmp.supplyOff     = val_reg[5];
    assign cmp.supplyOvp     = val_reg[6];
    assign cmp.supplyReset   = val_reg[7];
    assign cmp.faultInput    = val_reg[8];
endmodule

// file: design/hss_top.sv
// high-voltage startup sequencer: charge current choice, brown-in wait, ovp latch, soft start
`timescale 1ns/1ps
module hss_top
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // comparators, high when the level is above the threshold
    input  wire logic        lineDischargeCmp,
    input  wire logic        lineMinimumCmp,
    input  wire logic        lineBrownInCmp,
    input  wire logic        supplyInhibitCmp,
    input  wire logic        supplyOnCmp,
    input  wire logic        supplyOffCmp,
    input  wire logic        supplyOvpCmp,
    input  wire logic        supplyResetCmp,
    input  wire logic        faultInput,
    // remaining startup timers, from other blocks
    input  wire logic        timersDone,
    // current source controls
    output logic             lowChargeCurrent,
    output logic             highChargeCurrent,
    // status and switching
    output logic             ovpLatched,
    output logic             softStartActive,
    output logic             switchingEnable,
    output logic [11:0]      switchFreqKhz,
    input  wire logic [11:0] targetFreqKhz
);
    hss_cmp_if cmp ();

    hss_sync u_sync
    (
        .clk   (clk),
        .nrst  (nrst),
        .rawIn ({faultInput, supplyResetCmp, supplyOvpCmp, supplyOffCmp, supplyOnCmp,
                 supplyInhibitCmp, lineBrownInCmp, lineMinimumCmp, lineDischargeCmp}),
        .cmp   (cmp)
    );

    typedef enum logic [2:0] {ST_CHARGE, ST_WAIT, ST_RECHARGE, ST_DELAY, ST_HOLD, ST_SOFT, ST_RUN, ST_OVP}
        hss_state_e;

    hss_state_e                    state_reg, state_next;
    hss_pkg::hss_cur_e             cur_reg, cur_next;
    logic [hss_pkg::TIMER_W-1:0]   ovpCnt_reg, ovpCnt_next;
    logic [hss_pkg::TIMER_W-1:0]   offCnt_reg, offCnt_next;
    logic [hss_pkg::TIMER_W-1:0]   binCnt_reg, binCnt_next;
    logic [hss_pkg::TIMER_W-1:0]   dlyCnt_reg, dlyCnt_next;
    logic [hss_pkg::TIMER_W-1:0]   stepCnt_reg, stepCnt_next;
    logic                          brownIn_reg, brownIn_next;
    logic [11:0]                   freq_reg, freq_next;
    logic                          ovpHit, offHit, sourcing;

    function automatic logic [hss_pkg::TIMER_W-1:0] countUp(input logic cond,
                                                            input logic [hss_pkg::TIMER_W-1:0] cnt);
        // restart whenever the qualifying condition drops
        countUp = !cond ? '0 : (&cnt ? cnt : cnt + 1'b1);
    endfunction

    assign sourcing = (cur_reg != hss_pkg::CUR_OFF);
    assign ovpHit   = (ovpCnt_reg >= hss_pkg::TIMER_W'(hss_pkg::OVP_DELAY_CYC));
    assign offHit   = (offCnt_reg >= hss_pkg::TIMER_W'(hss_pkg::OFF_DELAY_CYC));

    always_comb
    begin
        ovpCnt_next = countUp(cmp.supplyOvp, ovpCnt_reg);
        offCnt_next = countUp(!cmp.supplyOff, offCnt_reg);
        // brown-in only assessed while no current is sourced
        binCnt_next = countUp(cmp.lineBrownIn && !sourcing, binCnt_reg);
        brownIn_next = brownIn_reg;
        if (!sourcing && binCnt_reg >= hss_pkg::TIMER_W'(hss_pkg::BROWNIN_DELAY_CYC))
        begin
            brownIn_next = 1'b1;
        end
        else if (!sourcing && !cmp.lineBrownIn)
        begin
            brownIn_next = 1'b0;
        end
        state_next  = state_reg;
        dlyCnt_next = '0;
        unique case (state_reg)
            ST_CHARGE:
            begin
                if (cmp.supplyOn)
                begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (brownIn_reg && !cmp.faultInput)
                begin
                    state_next = ST_RECHARGE;
                end
                else if (offHit)
                begin
                    state_next = ST_CHARGE;
                end
            end
            ST_RECHARGE:
            begin
                // supply must be at turn-on before the start delay; a fault goes back to charge
                if (cmp.faultInput)
                begin
                    state_next = ST_CHARGE;
                end
                else if (cmp.supplyOn)
                begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                dlyCnt_next = dlyCnt_reg + 1'b1;
                if (dlyCnt_reg >= hss_pkg::TIMER_W'(hss_pkg::START_DELAY_CYC - 1))
                begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (timersDone)
                begin
                    state_next = ST_SOFT;
                end
            end
            ST_SOFT:
            begin
                if (freq_reg >= targetFreqKhz)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
            end
            ST_OVP:
            begin
                if (!cmp.supplyReset)
                begin
                    state_next = ST_CHARGE;
                end
            end
        endcase
        if (state_reg != ST_OVP && ovpHit)
        begin
            state_next = ST_OVP;
        end
        else if (state_reg != ST_OVP && (state_reg == ST_SOFT || state_reg == ST_RUN || state_reg == ST_HOLD)
                 && cmp.faultInput)
        begin
            state_next = ST_CHARGE;
        end
    end

    // charge current choice; high needs supply past inhibit and line above minimum
    always_comb
    begin
        cur_next = hss_pkg::CUR_OFF;
        if ((state_next == ST_CHARGE || state_next == ST_RECHARGE) && !cmp.supplyOn)
        begin
            if (!cmp.supplyInhibit && cmp.lineDischarge)
            begin
                cur_next = hss_pkg::CUR_LOW;
            end
            else if (cmp.supplyInhibit && cmp.lineMinimum)
            begin
                cur_next = hss_pkg::CUR_HIGH;
            end
        end
    end

    // soft start frequency ramp
    always_comb
    begin
        freq_next    = freq_reg;
        stepCnt_next = '0;
        if (state_next == ST_SOFT && state_reg != ST_SOFT)
        begin
            freq_next = hss_pkg::SS_START_KHZ;
        end
        else if (state_reg == ST_SOFT)
        begin
            stepCnt_next = stepCnt_reg + 1'b1;
            if (stepCnt_reg >= hss_pkg::TIMER_W'(hss_pkg::SS_STEP_CYC - 1))
            begin
                stepCnt_next = '0;
                freq_next    = (freq_reg < targetFreqKhz) ? freq_reg + hss_pkg::SS_STEP_KHZ : freq_reg;
            end
        end
        else if (state_next != ST_RUN)
        begin
            freq_next = 12'h000;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg   <= ST_CHARGE;
            cur_reg     <= hss_pkg::CUR_OFF;
            ovpCnt_reg  <= '0;
            offCnt_reg  <= '0;
            binCnt_reg  <= '0;
            dlyCnt_reg  <= '0;
            stepCnt_reg <= '0;
            brownIn_reg <= 1'b0;
            freq_reg    <= 12'h000;
        end
        else
        begin
            state_reg   <= state_next;
            cur_reg     <= cur_next;
            ovpCnt_reg  <= ovpCnt_next;
            offCnt_reg  <= offCnt_next;
            binCnt_reg  <= binCnt_next;
            dlyCnt_reg  <= dlyCnt_next;
            stepCnt_reg <= stepCnt_next;
            brownIn_reg <= brownIn_next;
            freq_reg    <= freq_next;
        end
    end

    assign lowChargeCurrent  = (cur_reg == hss_pkg::CUR_LOW);
    assign highChargeCurrent = (cur_reg == hss_pkg::CUR_HIGH);
    assign ovpLatched        = (state_reg == ST_OVP);
    assign softStartActive   = (state_reg == ST_SOFT);
    assign switchingEnable   = (state_reg == ST_SOFT || state_reg == ST_RUN);
    assign switchFreqKhz     = freq_reg;

    a_cur_exclusive: assert property (@(posedge clk) disable iff (!nrst)
        !(lowChargeCurrent && highChargeCurrent)) else $error("both charge currents on");
    a_high_needs_min: assert property (@(posedge clk) disable iff (!nrst)
        highChargeCurrent |-> $past(cmp.lineMinimum) && !$past(cmp.supplyOn)) else $error("high current illegal");
    a_high_inhibit: assert property (@(posedge clk) disable iff (!nrst)
        highChargeCurrent |-> $past(cmp.supplyInhibit)) else $error("high current below inhibit");
    a_low_revert: assert property (@(posedge clk) disable iff (!nrst)
        lowChargeCurrent |-> !$past(cmp.supplyInhibit)) else $error("low current above inhibit");
    a_wait_off: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == ST_WAIT |-> !lowChargeCurrent && !highChargeCurrent) else $error("source on in wait");
    a_ovp_latch: assert property (@(posedge clk) disable iff (!nrst)
        ovpHit && state_reg != ST_OVP |=> ovpLatched) else $error("ovp not latched");
    a_ovp_hold: assert property (@(posedge clk) disable iff (!nrst)
        ovpLatched && $past(ovpLatched) && cmp.supplyReset |=> ovpLatched) else $error("ovp released early");
    a_delay_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(state_reg == ST_DELAY) |-> (state_reg == ST_DELAY)[*8]) else $error("start delay too short");
    a_hold_timers: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == ST_HOLD && !timersDone && !ovpHit && !cmp.faultInput |=> !switchingEnable)
        else $error("switching before timers");
    a_ss_start: assert property (@(posedge clk) disable iff (!nrst)
        $rose(softStartActive) |-> switchFreqKhz == hss_pkg::SS_START_KHZ) else $error("soft start not at 31 kHz");
    a_no_bo_sourcing: assert property (@(posedge clk) disable iff (!nrst)
        sourcing |=> binCnt_reg == '0) else $error("brownout assessed while sourcing");

    c_ovp: cover property (@(posedge clk) disable iff (!nrst) $rose(ovpLatched));
    c_soft: cover property (@(posedge clk) disable iff (!nrst) $rose(softStartActive));
    c_hyst: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_WAIT ##1 state_reg == ST_CHARGE);
    c_run: cover property (@(posedge clk) disable iff (!nrst) $rose(state_reg == ST_RUN));
endmodule

// file: dv/hss_supply_model.sv
// behavioural supply capacitor with its comparators, charged by the sequencer's sources
`timescale 1ns/1ps
module hss_supply_model
#(
    parameter int INHIBIT_MV = 700,
    parameter int OFF_MV     = 9900,
    parameter int ON_MV      = 15200,
    parameter int OVP_MV     = 20000,
    parameter int RESET_MV   = 5000,
    parameter int LOW_STEP   = 2,
    parameter int HIGH_STEP  = 25
)
(
    // clock
    input  wire logic        clk,
    // current source controls
    input  wire logic        lowChargeCurrent,
    input  wire logic        highChargeCurrent,
    // bench controls: load drain, short to ground, surge
    input  wire logic [15:0] drainMv,
    input  wire logic        dumpSupply,
    input  wire logic        ovpInject,
    // supply comparators
    output logic             supplyInhibitCmp,
    output logic             supplyOnCmp,
    output logic             supplyOffCmp,
    output logic             supplyOvpCmp,
    output logic             supplyResetCmp,
    output logic [15:0]      supplyMv
);
    initial supplyMv = 16'h0000;
    // drain only while no source runs, so a stuck source shows as a rising supply
    always @(posedge clk)
    begin
        if (ovpInject)
            supplyMv <= 16'(OVP_MV + 1000);
        else if (dumpSupply)
            supplyMv <= 16'h0000;
        else if (lowChargeCurrent || highChargeCurrent)
            supplyMv <= supplyMv + (highChargeCurrent ? 16'(HIGH_STEP) : 16'(LOW_STEP));
        else
            supplyMv <= (supplyMv > drainMv) ? supplyMv - drainMv : 16'h0000;
    end
    assign supplyInhibitCmp = supplyMv > 16'(INHIBIT_MV);
    assign supplyOnCmp      = supplyMv >= 16'(ON_MV);
    assign supplyOffCmp     = supplyMv > 16'(OFF_MV);
    assign supplyOvpCmp     = supplyMv > 16'(OVP_MV);
    assign supplyResetCmp   = supplyMv > 16'(RESET_MV);
endmodule

// file: dv/tb_top.sv
// self-checking bench for the high-voltage startup sequencer
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        lineDischargeCmp = 1'b1;
    logic        lineMinimumCmp = 1'b1;
    logic        lineBrownInCmp = 1'b0;
    logic        faultInput = 1'b0;
    logic        timersDone = 1'b0;
    logic [11:0] targetFreqKhz = 12'h0028;
    logic [15:0] drainMv = 16'h0000;
    logic        dumpSupply = 1'b0;
    logic        ovpInject = 1'b0;
    logic        supplyInhibitCmp, supplyOnCmp, supplyOffCmp, supplyOvpCmp, supplyResetCmp;
    logic        lowChargeCurrent, highChargeCurrent, ovpLatched, softStartActive, switchingEnable;
    logic [11:0] switchFreqKhz;
    logic [15:0] supplyMv;
    int          failures = 0;
    int          numChecks = 0;

    always #50 clk = ~clk;

    hss_top u_dut (.clk(clk), .nrst(nrst), .lineDischargeCmp(lineDischargeCmp), .lineMinimumCmp(lineMinimumCmp),
        .lineBrownInCmp(lineBrownInCmp), .supplyInhibitCmp(supplyInhibitCmp), .supplyOnCmp(supplyOnCmp),
        .supplyOffCmp(supplyOffCmp), .supplyOvpCmp(supplyOvpCmp), .supplyResetCmp(supplyResetCmp),
        .faultInput(faultInput), .timersDone(timersDone), .lowChargeCurrent(lowChargeCurrent),
        .highChargeCurrent(highChargeCurrent), .ovpLatched(ovpLatched), .softStartActive(softStartActive),
        .switchingEnable(switchingEnable), .switchFreqKhz(switchFreqKhz), .targetFreqKhz(targetFreqKhz));

    hss_supply_model u_supply (.clk(clk), .lowChargeCurrent(lowChargeCurrent), .highChargeCurrent(highChargeCurrent),
        .drainMv(drainMv), .dumpSupply(dumpSupply), .ovpInject(ovpInject), .supplyInhibitCmp(supplyInhibitCmp),
        .supplyOnCmp(supplyOnCmp), .supplyOffCmp(supplyOffCmp), .supplyOvpCmp(supplyOvpCmp),
        .supplyResetCmp(supplyResetCmp), .supplyMv(supplyMv));

    task automatic final_report();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        numChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chkb(input string name, input logic exp, input logic got);
        chk(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return lowChargeCurrent;
            1: return highChargeCurrent;
            2: return !(lowChargeCurrent || highChargeCurrent);
            3: return softStartActive;
            4: return switchingEnable;
            default: return ovpLatched;
        endcase
    endfunction

    // bounded wait; a bound that runs out is a mismatch and ends the run
    task automatic wait_sig(input int sel, input logic val, input int maxc, input string name);
        int n;
        n = 0;
        while (pick(sel) !== val && n < maxc)
        begin
            @(negedge clk);
            n++;
        end
        chkb(name, val, pick(sel));
        if (pick(sel) !== val)
            final_report();
    endtask

    task automatic count_on(input int sel, input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc)
        begin
            @(negedge clk);
            if (pick(sel) !== 1'b0)
                cnt++;
        end
    endtask

    task automatic check_charge();
        wait_sig(0, 1'b1, 30, "low current at start");
        chkb("high current at start", 1'b0, highChargeCurrent);
        wait_sig(1, 1'b1, 500, "high current above inhibit");
        chkb("low current with high", 1'b0, lowChargeCurrent);
        lineMinimumCmp = 1'b0;
        wait_sig(1, 1'b0, 12, "high current line under minimum");
        lineMinimumCmp = 1'b1;
        wait_sig(1, 1'b1, 12, "high current line back");
        dumpSupply = 1'b1;
        @(negedge clk);
        dumpSupply = 1'b0;
        wait_sig(1, 1'b0, 12, "high current under inhibit");
        chkb("low current under inhibit", 1'b1, lowChargeCurrent);
        wait_sig(2, 1'b1, 1500, "sources off at turn-on");
        chkb("supply at turn-on", 1'b1, supplyOnCmp);
    endtask

    task automatic check_hysteresis();
        int n;
        int offLow;
        n = 0;
        offLow = 0;
        drainMv = 16'h000A;
        while (!(lowChargeCurrent || highChargeCurrent) && n < 1200)
        begin
            @(negedge clk);
            n++;
            if (!supplyOffCmp)
                offLow++;
        end
        chkb("recharge after turn-off", 1'b1, lowChargeCurrent || highChargeCurrent);
        chkb("turn-off delay kept", 1'b1, offLow >= hss_pkg::OFF_DELAY_CYC);
        drainMv = 16'h0000;
        wait_sig(2, 1'b1, 1500, "turn-on reached again");
    endtask

    task automatic check_start();
        int cnt;
        lineBrownInCmp = 1'b1;
        count_on(4, 700, cnt);
        chk("switching before timers", 16'h0000, 16'(cnt));
        timersDone = 1'b1;
        wait_sig(3, 1'b1, 12, "soft start on timers");
        chk("soft start frequency", {4'h0, hss_pkg::SS_START_KHZ}, {4'h0, switchFreqKhz});
        repeat (256) @(negedge clk);
        chkb("frequency ramping", 1'b1, switchFreqKhz > hss_pkg::SS_START_KHZ && switchFreqKhz < targetFreqKhz);
        wait_sig(3, 1'b0, 800, "soft start ends");
        chkb("run at target", 1'b1, switchingEnable && switchFreqKhz >= targetFreqKhz);
    endtask

    task automatic check_fault();
        int cnt;
        faultInput = 1'b1;
        wait_sig(4, 1'b0, 12, "fault stops switching");
        count_on(4, 400, cnt);
        chk("switching while fault", 16'h0000, 16'(cnt));
        faultInput = 1'b0;
        cnt = 0;
        while (softStartActive !== 1'b1 && cnt < 1000)
        begin
            @(negedge clk);
            cnt++;
        end
        chkb("soft start after fault", 1'b1, softStartActive);
        chkb("start delay kept", 1'b1, cnt >= hss_pkg::START_DELAY_CYC);
    endtask

    task automatic check_ovp();
        int n;
        int cnt;
        ovpInject = 1'b1;
        repeat (150) @(negedge clk);
        ovpInject = 1'b0;
        drainMv = 16'h0400;
        repeat (5) @(negedge clk);
        ovpInject = 1'b1;
        drainMv = 16'h0000;
        repeat (150) @(negedge clk);
        chkb("split surge ignored", 1'b0, ovpLatched);
        wait_sig(5, 1'b1, 80, "overvoltage latched");
        @(negedge clk);
        chkb("stopped while latched", 1'b0, switchingEnable);
        ovpInject = 1'b0;
        drainMv = 16'h000A;
        n = 0;
        cnt = 0;
        while (supplyResetCmp && n < 2500)
        begin
            @(negedge clk);
            n++;
            if (ovpLatched !== 1'b1)
                cnt++;
        end
        chk("latch dropped above reset", 16'h0000, 16'(cnt));
        wait_sig(5, 1'b0, 12, "latch cleared below reset");
    endtask

    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        check_charge();
        check_hysteresis();
        check_start();
        check_fault();
        check_ovp();
        final_report();
    end
endmodule
